// [hdl/branch_bit_consts.vh]
`ifndef BRANCH_BIT_CONSTS_VH
`define BRANCH_BIT_CONSTS_VH

// ----------------------------------------------------------------
// Opcode low nibble groups
// ----------------------------------------------------------------
`define LO_CALL 4'h1
`define LO_JUMP 4'h9
`define LO_BTST 4'h3
`define LO_BMAN 4'hB
`define LO_CTRL 4'hD

// ----------------------------------------------------------------
// Control opcodes (high nibble with low nibble D)
// ----------------------------------------------------------------
`define HI_INT_EXIT 4'h4
`define HI_STOP 4'h6
`define HI_SUB_EXIT 4'hC
`define HI_WAIT 4'hE
`define HI_NOP 4'h0

// ----------------------------------------------------------------
// Short branch test kinds (opcode bits 2:1)
// ----------------------------------------------------------------
`define TEST_ZERO_CLR 2'h0
`define TEST_CARRY_CLR 2'h1
`define TEST_ZERO_SET 2'h2
`define TEST_CARRY_SET 2'h3

// ----------------------------------------------------------------
// Instruction cycle counts
// ----------------------------------------------------------------
`define CYC_SHORT 3'h2
`define CYC_BTST 3'h5
`define CYC_BMAN 3'h4
`define CYC_LONG 3'h4
`define CYC_CTRL 3'h2

`endif

// [hdl/bit_select.v]
`timescale 1ns/1ps
// Maps the three upper high-nibble bits to a bit number (0,4,2,6,1,5,3,7)
// and gives the selected bit of a data byte plus its set/clear result.
module bit_select (
    // Selection
    input wire [2:0] field_i,
    input wire polarity_i,
    // Data
    input wire [7:0] data_i,
    output wire bit_o,
    output wire [7:0] modified_o
);
    wire [2:0] bit_num;
    wire [7:0] mask;

    // Field bits are stored reversed in the opcode
    assign bit_num = {field_i[0], field_i[1], field_i[2]};
    assign mask = 8'h01 << bit_num;
    assign bit_o = data_i[bit_num];
    assign modified_o = polarity_i ? (data_i | mask) : (data_i & ~mask);

endmodule // bit_select

// [hdl/branch_bit_control_decoder.v]
`timescale 1ns/1ps
`include "branch_bit_consts.vh"
module branch_bit_control_decoder #(
    parameter PC_W = 12
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Options and flags
    input wire watchdog_opt_i,
    input wire carry_i,
    input wire zero_i,
    // Program memory
    input wire [7:0] prog_data_i,
    input wire prog_valid_i,
    output wire [PC_W-1:0] prog_addr_o,
    output wire prog_req_o,
    // Data space
    output reg [7:0] data_addr_o,
    output reg data_rd_o,
    input wire [7:0] data_rdata_i,
    output reg data_wr_o,
    output reg [7:0] data_wdata_o,
    // Flag updates and control events
    output reg carry_we_o,
    output reg carry_o,
    output reg call_push_o,
    output reg [PC_W-1:0] return_addr_o,
    output reg sub_exit_o,
    output reg int_exit_o,
    output reg stop_o,
    output reg wait_o,
    output reg instr_done_o,
    // Return address from stack
    input wire [PC_W-1:0] stack_top_i
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_FETCH = 3'h0;
    localparam [2:0] ST_OPER1 = 3'h1;
    localparam [2:0] ST_OPER2 = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_EXEC = 3'h4;
    localparam [2:0] ST_PAD = 3'h5;

    reg [2:0] state_reg, state_next;
    reg [PC_W-1:0] pc_reg, pc_next;
    reg [PC_W-1:0] ipc_reg, ipc_next;
    reg [7:0] opcode_reg, opcode_next;
    reg [7:0] oper1_reg, oper1_next;
    reg [7:0] oper2_reg, oper2_next;
    reg [7:0] rdata_reg, rdata_next;
    reg [2:0] cyc_reg, cyc_next;
    reg [2:0] len_reg, len_next;

    wire [3:0] lo = opcode_reg[3:0];
    wire [3:0] hi = opcode_reg[7:4];
    wire tested_bit;
    wire [7:0] modified_byte;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Low nibble with bit 0 clear marks a short relative branch
    function is_short;
        input [3:0] low;
        begin
            is_short = ~low[0];
        end
    endfunction

    // Condition test for short branches on bits 2:1 of the low nibble
    function short_cond;
        input [1:0] kind;
        input c;
        input z;
        begin
            case (kind)
                `TEST_ZERO_CLR: short_cond = ~z;
                `TEST_CARRY_CLR: short_cond = ~c;
                `TEST_ZERO_SET: short_cond = z;
                `TEST_CARRY_SET: short_cond = c;
                default: short_cond = 1'b0;
            endcase
        end
    endfunction

    function [2:0] instr_len;
        input [3:0] low;
        begin
            case (low)
                `LO_BTST: instr_len = 3'h3;
                `LO_BMAN, `LO_CALL, `LO_JUMP: instr_len = 3'h2;
                default: instr_len = 3'h1;
            endcase
        end
    endfunction

    bit_select u_bit_select (
        .field_i(hi[3:1]),
        .polarity_i(hi[0]),
        .data_i(rdata_reg),
        .bit_o(tested_bit),
        .modified_o(modified_byte)
    );

    assign prog_addr_o = pc_reg;
    assign prog_req_o = (state_reg == ST_FETCH) || (state_reg == ST_OPER1)
        || (state_reg == ST_OPER2);

    // Short span: 5-bit unsigned, magnitude opcode bits 7:4 plus one; direction taken from opcode bit 3.
    // Opcode bits 7:4 hold the span, bit 3 direction, giving -15..+16 with the +1 bias.
    wire [4:0] short_span = {1'b0, opcode_reg[7:4]} + 5'h01;
    wire [PC_W-1:0] short_target = opcode_reg[3] ?
        (ipc_reg - {{(PC_W-5){1'b0}}, short_span} + {{(PC_W-1){1'b0}}, 1'b1}) :
        (ipc_reg + {{(PC_W-5){1'b0}}, short_span});
    // Third byte is signed and counted from two past the opcode, giving -126..+129
    wire [PC_W-1:0] btst_target = ipc_reg + {{(PC_W-2){1'b0}}, 2'h2}
        + {{(PC_W-8){oper2_reg[7]}}, oper2_reg};
    wire [PC_W-1:0] long_target = {opcode_reg[7:4], oper1_reg};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        pc_next = pc_reg;
        ipc_next = ipc_reg;
        opcode_next = opcode_reg;
        oper1_next = oper1_reg;
        oper2_next = oper2_reg;
        rdata_next = rdata_reg;
        // Saturate so that long memory waits cannot wrap the count and pad again
        cyc_next = (cyc_reg == 3'h7) ? cyc_reg : cyc_reg + 3'h1;
        len_next = len_reg;
        case (state_reg)
            ST_FETCH: begin
                cyc_next = 3'h1;
                if (prog_valid_i) begin
                    opcode_next = prog_data_i;
                    ipc_next = pc_reg;
                    pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
                    len_next = instr_len(prog_data_i[3:0]);
                    state_next = (instr_len(prog_data_i[3:0]) == 3'h1) ? ST_EXEC : ST_OPER1;
                end else begin
                    cyc_next = 3'h0;
                end
            end
            ST_OPER1: begin
                if (prog_valid_i) begin
                    oper1_next = prog_data_i;
                    pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
                    if (len_reg == 3'h3)
                        state_next = ST_OPER2;
                    else if (lo == `LO_BMAN)
                        state_next = ST_DATA;
                    else
                        state_next = ST_EXEC;
                end
            end
            ST_OPER2: begin
                if (prog_valid_i) begin
                    oper2_next = prog_data_i;
                    pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                rdata_next = data_rdata_i;
                state_next = ST_EXEC;
            end
            ST_EXEC: begin
                if (is_short(lo)) begin
                    if (short_cond(lo[2:1], carry_i, zero_i))
                        pc_next = short_target;
                end else if (lo == `LO_BTST) begin
                    if (tested_bit == hi[0])
                        pc_next = btst_target;
                end else if (lo == `LO_CALL || lo == `LO_JUMP) begin
                    pc_next = long_target;
                end else if (lo == `LO_CTRL &&
                    (hi == `HI_SUB_EXIT || hi == `HI_INT_EXIT)) begin
                    pc_next = stack_top_i;
                end
                // Groups whose count is already spent skip the pad cycle
                if (cyc_reg >= target_cycles(lo) - 3'h1) begin
                    state_next = ST_FETCH;
                    cyc_next = 3'h0;
                end else begin
                    state_next = ST_PAD;
                end
            end
            ST_PAD: begin
                // Pad every instruction to its documented cycle count
                if (cyc_reg >= target_cycles(lo) - 3'h1) begin
                    state_next = ST_FETCH;
                    cyc_next = 3'h0;
                end
            end
            default: state_next = ST_FETCH;
        endcase
    end

    function [2:0] target_cycles;
        input [3:0] low;
        begin
            if (~low[0])
                target_cycles = `CYC_SHORT;
            else if (low == `LO_BTST)
                target_cycles = `CYC_BTST;
            else if (low == `LO_BMAN)
                target_cycles = `CYC_BMAN;
            else if (low == `LO_CALL || low == `LO_JUMP)
                target_cycles = `CYC_LONG;
            else
                target_cycles = `CYC_CTRL;
        end
    endfunction

    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_FETCH;
            pc_reg <= {PC_W{1'b0}};
            ipc_reg <= {PC_W{1'b0}};
            opcode_reg <= 8'h00;
            oper1_reg <= 8'h00;
            oper2_reg <= 8'h00;
            rdata_reg <= 8'h00;
            cyc_reg <= 3'h0;
            len_reg <= 3'h1;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            ipc_reg <= ipc_next;
            opcode_reg <= opcode_next;
            oper1_reg <= oper1_next;
            oper2_reg <= oper2_next;
            rdata_reg <= rdata_next;
            cyc_reg <= cyc_next;
            len_reg <= len_next;
        end
    end

    // ----------------------------------------------------------------
    // Registered side effects
    // ----------------------------------------------------------------
    // Flags are written only by bit-test branches; all other groups leave them
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            data_addr_o <= 8'h00;
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
            data_wdata_o <= 8'h00;
            carry_we_o <= 1'b0;
            carry_o <= 1'b0;
            call_push_o <= 1'b0;
            return_addr_o <= {PC_W{1'b0}};
            sub_exit_o <= 1'b0;
            int_exit_o <= 1'b0;
            stop_o <= 1'b0;
            wait_o <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            data_rd_o <= (state_next == ST_DATA);
            data_wr_o <= 1'b0;
            carry_we_o <= 1'b0;
            call_push_o <= 1'b0;
            sub_exit_o <= 1'b0;
            int_exit_o <= 1'b0;
            stop_o <= 1'b0;
            wait_o <= 1'b0;
            instr_done_o <= ((state_reg == ST_PAD) || (state_reg == ST_EXEC))
                && (state_next == ST_FETCH);
            if (state_next == ST_DATA)
                data_addr_o <= (state_reg == ST_OPER1) ? prog_data_i : oper1_reg;
            if (state_reg == ST_EXEC) begin
                if (lo == `LO_BTST) begin
                    carry_we_o <= 1'b1;
                    carry_o <= tested_bit;
                end
                if (lo == `LO_BMAN) begin
                    data_wr_o <= 1'b1;
                    data_wdata_o <= modified_byte;
                end
                if (lo == `LO_CALL) begin
                    call_push_o <= 1'b1;
                    return_addr_o <= pc_reg;
                end
                if (lo == `LO_CTRL) begin
                    sub_exit_o <= (hi == `HI_SUB_EXIT);
                    int_exit_o <= (hi == `HI_INT_EXIT);
                    stop_o <= (hi == `HI_STOP) && !watchdog_opt_i;
                    wait_o <= (hi == `HI_WAIT)
                        || ((hi == `HI_STOP) && watchdog_opt_i);
                end
            end
        end
    end

endmodule // branch_bit_control_decoder

// [sim/branch_bit_control_decoder_properties.sv]
`timescale 1ns/1ps
`include "branch_bit_consts.vh"
module branch_bit_control_decoder_properties #(
    parameter PC_W = 12
) (
    // Clock, reset and option
    input wire sys_clk_i, input wire reset_i, input wire watchdog_opt_i,
    // Program memory
    input wire [7:0] prog_data_i, input wire prog_valid_i,
    input wire [PC_W-1:0] prog_addr_o, input wire prog_req_o,
    // Data space and carry
    input wire data_rd_o, input wire [7:0] data_rdata_i,
    input wire data_wr_o, input wire [7:0] data_wdata_o,
    input wire carry_we_o, input wire carry_o,
    // Events
    input wire call_push_o, input wire [PC_W-1:0] return_addr_o,
    input wire sub_exit_o, input wire int_exit_o, input wire stop_o,
    input wire wait_o, input wire instr_done_o
);
    // ----------------------------------------------------------------
    // Opcode tracking
    // ----------------------------------------------------------------
    reg new_reg;
    reg [7:0] op_reg;
    reg [7:0] rd_reg;
    reg [PC_W-1:0] pc_reg;
    wire take = prog_req_o && prog_valid_i;
    wire [2:0] bnum = {op_reg[5], op_reg[6], op_reg[7]};
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            new_reg <= 1'b1;
        end else begin
            // The byte taken after a done pulse starts the next instruction
            new_reg <= take ? 1'b0 : (new_reg | instr_done_o);
            if (take && (new_reg || instr_done_o)) begin
                op_reg <= prog_data_i;
                pc_reg <= prog_addr_o;
            end
            if (data_rd_o) begin
                rd_reg <= data_rdata_i;
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_write_back;
        ##[1:3] data_wr_o;
    endsequence
    sequence s_carry_load;
        ##[1:3] carry_we_o;
    endsequence
    a_done_one_cycle: assert property (instr_done_o |=> !instr_done_o)
        else $error("done pulse too long");
    a_events_exclusive: assert property ($onehot0({call_push_o, sub_exit_o,
        int_exit_o, stop_o, wait_o, carry_we_o, data_wr_o})) else $error("events overlap");
    a_carry_from_bit: assert property (carry_we_o |-> op_reg[3:0] == `LO_BTST
        && carry_o == rd_reg[bnum]) else $error("carry not the tested bit");
    a_write_one_bit: assert property (data_wr_o |-> op_reg[3:0] == `LO_BMAN
        && data_wdata_o[bnum] == op_reg[4]
        && ((data_wdata_o ^ rd_reg) & ~(8'h01 << bnum)) == 8'h00) else $error("bad write");
    a_bman_writes: assert property (data_rd_o && op_reg[3:0] == `LO_BMAN |-> s_write_back)
        else $error("no write back");
    a_btst_loads: assert property (data_rd_o && op_reg[3:0] == `LO_BTST |-> s_carry_load)
        else $error("no carry load");
    a_call_return: assert property (call_push_o |-> op_reg[3:0] == `LO_CALL
        && return_addr_o == pc_reg + 2'h2) else $error("bad return address");
    a_stop_swap: assert property (stop_o || wait_o |-> op_reg[3:0] == `LO_CTRL
        && (stop_o ? !watchdog_opt_i : (op_reg[7:4] == `HI_WAIT || watchdog_opt_i)))
        else $error("bad stop or wait");
endmodule // branch_bit_control_decoder_properties
bind branch_bit_control_decoder branch_bit_control_decoder_properties #(.PC_W(PC_W))
    branch_bit_control_decoder_properties_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .watchdog_opt_i(watchdog_opt_i),
    .prog_data_i(prog_data_i), .prog_valid_i(prog_valid_i), .prog_addr_o(prog_addr_o),
    .prog_req_o(prog_req_o), .data_rd_o(data_rd_o), .data_rdata_i(data_rdata_i),
    .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .carry_we_o(carry_we_o),
    .carry_o(carry_o), .call_push_o(call_push_o), .return_addr_o(return_addr_o),
    .sub_exit_o(sub_exit_o), .int_exit_o(int_exit_o), .stop_o(stop_o), .wait_o(wait_o),
    .instr_done_o(instr_done_o)
);

// [sim/core_memory_model.sv]
`timescale 1ns/1ps
module core_memory_model (
    // Clock, reset, pacing
    input wire sys_clk_i, input wire reset_i, input wire slow_i,
    // Program memory
    input wire [11:0] prog_addr_i, input wire prog_req_i,
    output logic [7:0] prog_data_o, output logic prog_valid_o,
    // Data space
    input wire [7:0] data_addr_i, input wire data_rd_i, output logic [7:0] data_rdata_o,
    input wire data_wr_i, input wire [7:0] data_wdata_i
);
    logic [7:0] prog [0:4095];
    logic [7:0] dmem [0:255];
    logic phase_reg;
    always @(posedge sys_clk_i) begin
        phase_reg <= reset_i ? 1'b0 : ~phase_reg;
        if (data_wr_i) begin
            dmem[data_addr_i] <= data_wdata_i;
        end
    end
    // Slow mode answers every other cycle; idle buses show inverted data
    assign prog_valid_o = prog_req_i && (!slow_i || phase_reg);
    assign prog_data_o = prog_valid_o ? prog[prog_addr_i] : ~prog[prog_addr_i];
    assign data_rdata_o = data_rd_i ? dmem[data_addr_i] : ~dmem[data_addr_i];
endmodule // core_memory_model

// [sim/branch_bit_control_decoder_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t mismatch got %0h exp %0h", $time, a, b); end end
module branch_bit_control_decoder_tb_top;
    logic sys_clk_i, reset_i, watchdog_opt_i, carry_i, zero_i, prog_valid_i, slow, new_q;
    logic [7:0] prog_data_i, data_rdata_i, data_addr_o, data_wdata_o;
    logic [11:0] prog_addr_o, return_addr_o, stack_top_i;
    logic prog_req_o, data_rd_o, data_wr_o, carry_we_o, carry_o, call_push_o;
    logic sub_exit_o, int_exit_o, stop_o, wait_o, instr_done_o;
    logic [11:0] log_pc[$], exp_pc[$];
    logic cw_q[$];
    int log_cyc[$], exp_cyc[$];
    int ev_n[5];
    int cyc, mismatches, n_tests;
    branch_bit_control_decoder branch_bit_control_decoder_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .watchdog_opt_i(watchdog_opt_i),
        .carry_i(carry_i), .zero_i(zero_i), .prog_data_i(prog_data_i),
        .prog_valid_i(prog_valid_i), .prog_addr_o(prog_addr_o), .prog_req_o(prog_req_o),
        .data_addr_o(data_addr_o), .data_rd_o(data_rd_o), .data_rdata_i(data_rdata_i),
        .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .carry_we_o(carry_we_o),
        .carry_o(carry_o), .call_push_o(call_push_o), .return_addr_o(return_addr_o),
        .sub_exit_o(sub_exit_o), .int_exit_o(int_exit_o), .stop_o(stop_o),
        .wait_o(wait_o), .instr_done_o(instr_done_o), .stack_top_i(stack_top_i)
    );
    core_memory_model core_memory_model_i (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .slow_i(slow),
        .prog_addr_i(prog_addr_o), .prog_req_i(prog_req_o), .prog_data_o(prog_data_i),
        .prog_valid_o(prog_valid_i), .data_addr_i(data_addr_o), .data_rd_i(data_rd_o),
        .data_rdata_o(data_rdata_i), .data_wr_i(data_wr_o), .data_wdata_i(data_wdata_o)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------------------------------
    // Monitor: an opcode is the first byte taken after a done pulse
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        cyc++;
        if (reset_i) begin
            new_q = 1'b1;
            log_pc.delete();
            log_cyc.delete();
            cw_q.delete();
            ev_n = '{0, 0, 0, 0, 0};
        end else begin
            if (prog_req_o && prog_valid_i && (new_q || instr_done_o)) begin
                log_pc.push_back(prog_addr_o);
                log_cyc.push_back(cyc);
            end
            new_q = (prog_req_o && prog_valid_i) ? 1'b0 : (new_q | instr_done_o);
            if (carry_we_o) cw_q.push_back(carry_o);
            ev_n[0] += call_push_o;
            ev_n[1] += sub_exit_o;
            ev_n[2] += int_exit_o;
            ev_n[3] += stop_o;
            ev_n[4] += wait_o;
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic put(input int a, input logic [7:0] d);
        core_memory_model_i.prog[a] = d;
    endtask
    task automatic prep(input logic s, input logic w, input logic c, input logic z);
        @(posedge sys_clk_i);
        #5;
        reset_i = 1'b1;
        slow = s;
        watchdog_opt_i = w;
        carry_i = c;
        zero_i = z;
        for (int i = 0; i < 4096; i++) put(i, 8'h0D);
        for (int i = 0; i < 256; i++) core_memory_model_i.dmem[i] = 8'h00;
    endtask
    task automatic run_check();
        int k;
        repeat (6) @(posedge sys_clk_i);
        #5;
        reset_i = 1'b0;
        k = 0;
        while (log_pc.size() <= exp_pc.size() && k < 500) begin
            @(posedge sys_clk_i);
            k++;
        end
        if (k >= 500) begin
            mismatches++;
            $display("ERROR %0t program trace timed out", $time);
        end
        for (int i = 0; i < exp_pc.size(); i++) begin
            `CHK(log_pc[i], exp_pc[i])
            if (!slow && i > 0) `CHK(log_cyc[i] - log_cyc[i-1], exp_cyc[i-1])
        end
    endtask
    task automatic t_short();
        prep(1'b0, 1'b0, 1'b1, 1'b0);
        put(0, 8'hF6);
        put(16, 8'hF4);
        put(17, 8'h30);
        put(21, 8'hF2);
        put(22, 8'hFE);
        put(7, 8'h18);
        exp_pc = '{12'h000, 12'h010, 12'h011, 12'h015, 12'h016, 12'h007, 12'h006};
        exp_cyc = '{2, 2, 2, 2, 2, 2};
        run_check();
    endtask
    task automatic t_btst();
        prep(1'b0, 1'b0, 1'b0, 1'b1);
        core_memory_model_i.dmem[64] = 8'h10;
        put(0, 8'h33);
        put(1, 8'h40);
        put(2, 8'h7F);
        put(129, 8'h23);
        put(130, 8'h40);
        put(131, 8'h80);
        put(132, 8'h03);
        put(133, 8'h40);
        put(134, 8'h80);
        exp_pc = '{12'h000, 12'h081, 12'h084, 12'h006};
        exp_cyc = '{5, 5, 5};
        run_check();
        for (int i = 0; i < 3; i++) `CHK(cw_q[i], i < 2)
    endtask
    task automatic t_bits();
        prep(1'b0, 1'b0, 1'b0, 1'b0);
        core_memory_model_i.dmem[33] = 8'hFF;
        exp_pc.delete();
        exp_cyc.delete();
        for (int b = 0; b < 8; b++) begin
            put(2 * b, {b[0], b[1], b[2], 5'h1B});
            put(2 * b + 1, 8'h20);
            put(2 * b + 16, {b[0], b[1], b[2], 5'h0B});
            put(2 * b + 17, 8'h21);
        end
        for (int i = 0; i <= 16; i++) begin
            exp_pc.push_back(12'(2 * i));
            exp_cyc.push_back(4);
        end
        run_check();
        `CHK(core_memory_model_i.dmem[32], 8'hFF)
        `CHK(core_memory_model_i.dmem[33], 8'h00)
        `CHK(cw_q.size(), 0)
    endtask
    task automatic t_long(input logic s);
        prep(s, 1'b0, 1'b0, 1'b0);
        stack_top_i = 12'h0FE;
        put(0, 8'hA1);
        put(1, 8'h23);
        put(12'hA23, 8'h59);
        put(12'hA24, 8'h10);
        put(12'h510, 8'hCD);
        put(12'h0FE, 8'h4D);
        exp_pc = '{12'h000, 12'hA23, 12'h510, 12'h0FE, 12'h0FE};
        exp_cyc = '{4, 4, 2, 2};
        run_check();
        `CHK(ev_n[0], 1)
        `CHK(ev_n[1], 1)
        `CHK(ev_n[2], 2)
        `CHK(cw_q.size(), 0)
    endtask
    task automatic t_ctrl(input logic w);
        prep(1'b0, w, 1'b0, 1'b1);
        put(0, 8'h6D);
        put(1, 8'hED);
        put(3, 8'h8D);
        put(4, 8'h07);
        put(5, 8'h12);
        put(7, 8'h24);
        put(10, 8'h06);
        put(11, 8'h00);
        exp_pc = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h007,
            12'h00A, 12'h00B, 12'h00C};
        exp_cyc = '{2, 2, 2, 2, 2, 2, 2, 2, 2};
        run_check();
        `CHK(ev_n[3], w ? 0 : 1)
        `CHK(ev_n[4], w ? 2 : 1)
        `CHK(cw_q.size(), 0)
    endtask
    initial begin
        reset_i = 1'b1;
        watchdog_opt_i = 1'b0;
        carry_i = 1'b0;
        zero_i = 1'b0;
        slow = 1'b0;
        stack_top_i = 12'h0FE;
        t_short();
        t_btst();
        t_bits();
        t_long(1'b0);
        t_long(1'b1);
        t_ctrl(1'b0);
        t_ctrl(1'b1);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        complete_run();
    end
endmodule // branch_bit_control_decoder_tb_top
